// file: rbf_pkg.sv
// shared constants and types of the rf burst framer
package rbf_pkg;

  // clock and bit rate, the bit enable is a fractional divider
  localparam int unsigned CLK_HZ   = 50_000_000;
  localparam int unsigned BIT_HZ   = 20_000_000;
  localparam int unsigned RATE_GCD = 10_000_000;
  localparam logic [2:0]  RATE_NUM = 3'(BIT_HZ / RATE_GCD);
  localparam logic [2:0]  RATE_DEN = 3'(CLK_HZ / RATE_GCD);

  // first bit must leave within this time of the scheduled instant
  localparam int unsigned TX_TOL_NS  = 1000;
  localparam int unsigned TX_TOL_CYC = TX_TOL_NS / (1_000_000_000 / CLK_HZ);

  // burst section lengths in bits
  localparam int unsigned PRE_BITS  = 128;
  localparam int unsigned UNIT_BITS = 16;
  localparam int unsigned SYNC_BITS = 64;
  localparam int unsigned TAIL_BITS = 2;
  localparam int unsigned CB_BITS   = 6144;

  // codeblocks per frame limits and value after reset
  localparam logic [4:0] BLK_MIN   = 5'h01;
  localparam logic [4:0] BLK_MAX   = 5'h10;
  localparam logic [4:0] BLK_RESET = 5'h01;

  // preamble halves, first bit in the msb, and the frame sync marker
  localparam logic [7:0]  PRE_I  = 8'hAA;
  localparam logic [7:0]  PRE_Q  = 8'hB4;
  localparam logic [63:0] MARKER = 64'h034776C7272895B0;

  // serial bit toward the modulator
  typedef struct packed {
    logic valid;  // one-cycle strobe per channel bit
    logic data;   // channel bit
    logic sof;    // first preamble bit of a burst
    logic eob;    // last tail bit of a burst
  } rbf_bit_t;

endpackage

// file: rbf_framer.sv
// transmit burst framer: preamble, marker, codeblocks, tail
`timescale 1ns/1ps
module rbf_framer #(
  parameter int unsigned CB_BITS = rbf_pkg::CB_BITS  // bits per codeblock
) (
  input  wire logic           ref_clk_i,     // 50 MHz clock
  input  wire logic           reset_i,       // async reset, high
  input  wire logic           cfg_load_i,    // load codeblock count
  input  wire logic [4:0]     cfg_blocks_i,  // codeblocks per frame
  input  wire logic           tx_start_i,    // scheduled instant pulse
  input  wire logic           cb_valid_i,    // codeblock bit valid
  input  wire logic           cb_bit_i,      // scrambled codeblock bit
  output logic                cb_ready_o,    // codeblock bit taken
  output rbf_pkg::rbf_bit_t   tx_o,          // serial bit to modulator
  output logic                flush_o,       // trellis to zero state
  output logic                busy_o,        // burst in progress
  output logic [4:0]          blocks_o,      // count now in force
  output logic                cfg_err_o,     // last load refused
  output logic                underrun_o     // data missing this burst
);

  localparam int TOL_CYC = rbf_pkg::TX_TOL_CYC;

  typedef enum logic [4:0] {
    RBF_IDLE = 5'h01,
    RBF_PRE  = 5'h02,
    RBF_SYNC = 5'h04,
    RBF_DATA = 5'h08,
    RBF_TAIL = 5'h10
  } rbf_state_t;

  ////////////////////////////////////////////////////////////////////////
  // bit rate enable

  logic [2:0] acc;
  logic [2:0] next_acc;
  logic       bit_en;

  // 2 of every 5 clocks, so bits come out 2 or 3 clocks apart
  always_comb begin
    next_acc = acc + rbf_pkg::RATE_NUM;
    bit_en   = 1'b0;
    if (next_acc >= rbf_pkg::RATE_DEN) begin
      next_acc = next_acc - rbf_pkg::RATE_DEN;
      bit_en   = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      acc <= 3'h0;
    end else begin
      acc <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // preamble unit built from the I and Q halves

  logic [15:0] pre_unit;

  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_unit
      assign pre_unit[15-2*k] = rbf_pkg::PRE_I[7-k];
      assign pre_unit[14-2*k] = rbf_pkg::PRE_Q[7-k];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // configuration

  logic [4:0] blocks;
  logic [4:0] next_blocks;
  logic       cfg_err;
  logic       next_cfg_err;
  rbf_state_t state;

  // loads during a burst are ignored so the frame in flight is intact
  always_comb begin
    next_blocks  = blocks;
    next_cfg_err = cfg_err;
    if (cfg_load_i && state == RBF_IDLE) begin
      if (cfg_blocks_i >= rbf_pkg::BLK_MIN &&
          cfg_blocks_i <= rbf_pkg::BLK_MAX) begin
        next_blocks  = cfg_blocks_i;
        next_cfg_err = 1'b0;
      end else begin
        next_cfg_err = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      blocks  <= rbf_pkg::BLK_RESET;
      cfg_err <= 1'b0;
    end else begin
      blocks  <= next_blocks;
      cfg_err <= next_cfg_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // burst sequencer

  rbf_state_t        next_state;
  logic [12:0]       cnt;
  logic [12:0]       next_cnt;
  logic [4:0]        blk;
  logic [4:0]        next_blk;
  logic              under;
  logic              next_under;
  rbf_pkg::rbf_bit_t next_tx;
  logic              flush;

  // handshake only while codeblock bits are due
  assign cb_ready_o = (state == RBF_DATA) && bit_en;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_blk   = blk;
    next_under = under;
    next_tx    = '0;
    flush      = 1'b0;
    case (state)
      RBF_IDLE: begin
        if (tx_start_i) begin
          // zero the trellis before any preamble bit
          flush      = 1'b1;
          next_state = RBF_PRE;
          next_cnt   = 13'h0;
          next_blk   = 5'h00;
          next_under = 1'b0;
        end
      end
      RBF_PRE: begin
        if (bit_en) begin
          next_tx.valid = 1'b1;
          next_tx.sof   = (cnt == 13'h0);
          next_tx.data  = pre_unit[4'hF - cnt[3:0]];
          next_cnt      = cnt + 13'h1;
          if (cnt == 13'(rbf_pkg::PRE_BITS - 1)) begin
            next_state = RBF_SYNC;
            next_cnt   = 13'h0;
          end
        end
      end
      RBF_SYNC: begin
        if (bit_en) begin
          // marker goes out raw, scrambling is upstream
          next_tx.valid = 1'b1;
          next_tx.data  = rbf_pkg::MARKER[6'h3F - cnt[5:0]];
          next_cnt      = cnt + 13'h1;
          if (cnt == 13'(rbf_pkg::SYNC_BITS - 1)) begin
            next_state = RBF_DATA;
            next_cnt   = 13'h0;
          end
        end
      end
      RBF_DATA: begin
        if (bit_en) begin
          // rate is fixed, so a missing bit is sent as zero and flagged
          next_tx.valid = 1'b1;
          next_tx.data  = cb_valid_i & cb_bit_i;
          next_under    = under | ~cb_valid_i;
          next_cnt      = cnt + 13'h1;
          if (cnt == 13'(CB_BITS - 1)) begin
            next_cnt = 13'h0;
            next_blk = blk + 5'h01;
            if (blk == blocks - 5'h01) begin
              next_state = RBF_TAIL;
            end
          end
        end
      end
      RBF_TAIL: begin
        if (bit_en) begin
          next_tx.valid = 1'b1;
          next_tx.data  = 1'b0;
          next_cnt      = cnt + 13'h1;
          if (cnt == 13'(rbf_pkg::TAIL_BITS - 1)) begin
            next_tx.eob = 1'b1;
            next_state  = RBF_IDLE;
            next_cnt    = 13'h0;
          end
        end
      end
      default: begin
        next_state = RBF_IDLE;
        next_cnt   = 13'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state   <= RBF_IDLE;
      cnt     <= 13'h0;
      blk     <= 5'h00;
      under   <= 1'b0;
      tx_o    <= '0;
      flush_o <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      blk     <= next_blk;
      under   <= next_under;
      tx_o    <= next_tx;
      flush_o <= flush;
    end
  end

  // status straight from registers
  assign busy_o     = (state != RBF_IDLE);
  assign blocks_o   = blocks;
  assign cfg_err_o  = cfg_err;
  assign underrun_o = under;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_order;
    @(posedge ref_clk_i) disable iff (reset_i)
      state != $past(state) |->
        (state == RBF_SYNC && $past(state) == RBF_PRE) ||
        (state == RBF_DATA && $past(state) == RBF_SYNC) ||
        (state == RBF_TAIL && $past(state) == RBF_DATA) ||
        (state == RBF_IDLE && $past(state) == RBF_TAIL) ||
        (state == RBF_PRE && $past(state) == RBF_IDLE);
  endproperty
  a_order: assert property (p_order)
    else $error("burst sections out of order");

  property p_tail_zero;
    @(posedge ref_clk_i) disable iff (reset_i)
      state == RBF_TAIL && bit_en |=> tx_o.valid && !tx_o.data;
  endproperty
  a_tail_zero: assert property (p_tail_zero)
    else $error("tail bit not zero");

  property p_blocks_range;
    @(posedge ref_clk_i) disable iff (reset_i)
      blocks >= rbf_pkg::BLK_MIN && blocks <= rbf_pkg::BLK_MAX;
  endproperty
  a_blocks_range: assert property (p_blocks_range)
    else $error("codeblock count out of range");

  property p_blocks_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
      !(cfg_load_i && state == RBF_IDLE) |=> $stable(blocks);
  endproperty
  a_blocks_hold: assert property (p_blocks_hold)
    else $error("codeblock count changed without load");

  property p_flush;
    @(posedge ref_clk_i) disable iff (reset_i)
      state == RBF_IDLE && tx_start_i |=>
        flush_o && state == RBF_PRE && !tx_o.valid;
  endproperty
  a_flush: assert property (p_flush)
    else $error("preamble without trellis flush");

  property p_pre_bit;
    @(posedge ref_clk_i) disable iff (reset_i)
      state == RBF_PRE && bit_en |=>
        tx_o.data == pre_unit[4'hF - $past(cnt[3:0])];
  endproperty
  a_pre_bit: assert property (p_pre_bit)
    else $error("wrong preamble bit");

  property p_pre_len;
    @(posedge ref_clk_i) disable iff (reset_i)
      state == RBF_SYNC && $past(state) == RBF_PRE |->
        $past(cnt) == 13'(rbf_pkg::PRE_BITS - 1);
  endproperty
  a_pre_len: assert property (p_pre_len)
    else $error("preamble length wrong");

  property p_marker;
    @(posedge ref_clk_i) disable iff (reset_i)
      state == RBF_SYNC && bit_en |=>
        tx_o.data == rbf_pkg::MARKER[6'h3F - $past(cnt[5:0])];
  endproperty
  a_marker: assert property (p_marker)
    else $error("wrong marker bit");

  property p_start_time;
    @(posedge ref_clk_i) disable iff (reset_i)
      state == RBF_IDLE && tx_start_i |->
        ##[1:TOL_CYC] tx_o.valid && tx_o.sof;
  endproperty
  a_start_time: assert property (p_start_time)
    else $error("first bit late");

  property p_rate;
    @(posedge ref_clk_i) disable iff (reset_i)
      tx_o.valid |=> !tx_o.valid;
  endproperty
  a_rate: assert property (p_rate)
    else $error("bits closer than the bit rate");

  property p_ready;
    @(posedge ref_clk_i) disable iff (reset_i)
      cb_ready_o |-> state == RBF_DATA ##1 tx_o.valid;
  endproperty
  a_ready: assert property (p_ready)
    else $error("codeblock taken outside data");

endmodule

// file: rbf_src_model.sv
// upstream codeblock bit source model for the burst framer
`timescale 1ns/1ps
module rbf_src_model (
  input  wire logic ref_clk_i,   // framer clock
  input  wire logic reset_i,     // async reset, high
  input  wire logic en_i,        // offer data when high
  input  wire logic cb_ready_i,  // framer takes a bit
  output logic      cb_valid_o,  // bit on offer
  output logic      cb_bit_o     // bit value
);
  logic [15:0] idx;          // bits handed over so far
  logic [15:0] next_idx;     // index of the bit to show next
  logic        took = 1'b0;  // framer took a bit at the last edge
  //////////////////////////////////////////////////////////////////////
  // bit j of the stream, the same pattern the bench predicts
  function automatic logic pat(input logic [15:0] j);
    return j[1] ^ j[0] ^ j[4] ^ (j[3:0] == 4'hF);
  endfunction
  // note the take on the sampling edge, lines move only after it
  always @(posedge ref_clk_i) begin
    took <= cb_ready_i && cb_valid_o;
  end
  assign next_idx = took ? idx + 16'h0001 : idx;
  // hold a bit until taken; off-line data toggles so it is never stale
  always @(negedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx        <= 16'h0000;
      cb_valid_o <= 1'b0;
      cb_bit_o   <= 1'b0;
    end else begin
      idx        <= next_idx;
      cb_valid_o <= en_i;
      cb_bit_o   <= en_i ? pat(next_idx) : ~cb_bit_o;
    end
  end
endmodule

// file: tb_top.sv
// self-checking bench for the rf burst framer
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned CBB = 8;  // short codeblocks keep runs brief
  logic ref_clk_i = 1'b0, reset_i = 1'b1, cfg_load_i = 1'b0;
  logic tx_start_i = 1'b0, src_en = 1'b1;
  logic [4:0] cfg_blocks_i = 5'h01, blocks_o;
  logic cb_valid_i, cb_bit_i, cb_ready_o, flush_o, busy_o;
  logic cfg_err_o, underrun_o;
  rbf_pkg::rbf_bit_t tx_o;
  int n_fail = 0, checks_done = 0, cyc = 0, sent = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  rbf_framer #(.CB_BITS(CBB)) u_dut (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .cfg_load_i(cfg_load_i),
    .cfg_blocks_i(cfg_blocks_i), .tx_start_i(tx_start_i),
    .cb_valid_i(cb_valid_i), .cb_bit_i(cb_bit_i),
    .cb_ready_o(cb_ready_o), .tx_o(tx_o), .flush_o(flush_o),
    .busy_o(busy_o), .blocks_o(blocks_o), .cfg_err_o(cfg_err_o),
    .underrun_o(underrun_o));
  rbf_src_model u_src (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .en_i(src_en), .cb_ready_i(cb_ready_o), .cb_valid_o(cb_valid_i),
    .cb_bit_o(cb_bit_i));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // cut a hang short well past the longest expected run
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // bit n of the source stream, same order the source hands them out
  function automatic logic src_bit(input int n);
    logic [15:0] j;
    j = 16'(n);
    return (j[1] + j[0]) ^ j[4] ^ (j[3:0] == 4'hF);
  endfunction
  // expected channel bit i of a burst of nb codeblocks
  function automatic logic exp_bit(input int i, input int nb,
                                   input logic en);
    logic [15:0] unit;
    int d;
    for (int k = 0; k < 8; k++) begin
      unit[15-2*k] = rbf_pkg::PRE_I[7-k];
      unit[14-2*k] = rbf_pkg::PRE_Q[7-k];
    end
    d = i - 192;
    if (i < 128) return unit[15 - i % 16];
    if (i < 192) return rbf_pkg::MARKER[191 - i];
    if (d < nb * CBB) return en ? src_bit(sent + d) : 1'b0;
    return 1'b0;
  endfunction
  task automatic load(input logic [4:0] v);
    @(negedge ref_clk_i);
    cfg_blocks_i = v;
    cfg_load_i = 1'b1;
    @(negedge ref_clk_i);
    cfg_load_i = 1'b0;
  endtask
  // one burst; poke fires start and load while busy, both to be ignored
  task automatic burst(input int nb, input logic en, input logic poke);
    int nbit, gap, lat, total, mk, nrdy;
    logic eob;
    logic [63:0] sh;
    nbit = 0;
    mk = -1;
    nrdy = 0;
    sh = '0;
    gap = 0;
    lat = 0;
    eob = 1'b0;
    total = 128 + 64 + nb * CBB + 2;
    src_en = en;
    @(negedge ref_clk_i);
    tx_start_i = 1'b1;
    @(negedge ref_clk_i);
    tx_start_i = 1'b0;
    check("flush", flush_o, 1);
    check("busy", busy_o, 1);
    while (!eob && lat < 4000) begin
      @(negedge ref_clk_i);
      lat++;
      gap++;
      tx_start_i = poke && nbit == 20;
      cfg_load_i = poke && nbit == 20;
      cfg_blocks_i = 5'h05;
      if (cb_ready_o === 1'b1) nrdy++;
      if (tx_o.valid === 1'b1) begin
        if (nbit == 0) check("latency", lat <= 50, 1);
        else check("spacing", gap == 2 || gap == 3, 1);
        check("sof", tx_o.sof, nbit == 0);
        check("eob", tx_o.eob, nbit == total - 1);
        check($sformatf("bit %0d", nbit), tx_o.data,
              exp_bit(nbit, nb, en));
        // a receiver finds the frame boundary by matching the marker
        sh = {sh[62:0], tx_o.data};
        if (sh == rbf_pkg::MARKER && mk < 0) mk = nbit;
        eob = tx_o.eob;
        gap = 0;
        nbit++;
      end
    end
    check("bit count", nbit, total);
    check("marker end", mk, 191);
    check("ready count", nrdy, nb * CBB);
    check("idle after tail", busy_o, 0);
    check("underrun", underrun_o, !en);
    if (en) sent += nb * CBB;
    src_en = 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("blocks", blocks_o, 1);
    check("cfg_err", cfg_err_o, 0);
    check("busy", busy_o, 0);
    check("tx valid", tx_o.valid, 0);
    $display("test reset done");
  endtask
  task automatic t_cfg;
    logic [4:0] v [4] = '{5'h00, 5'h11, 5'h10, 5'h01};
    logic [4:0] b [4] = '{5'h01, 5'h01, 5'h10, 5'h01};
    for (int k = 0; k < 4; k++) begin
      load(v[k]);
      check("blocks", blocks_o, b[k]);
      check("cfg_err", cfg_err_o, k < 2);
    end
    $display("test cfg done");
  endtask
  task automatic t_bursts;
    burst(1, 1'b1, 1'b0);
    load(5'h10);
    burst(16, 1'b1, 1'b1);
    check("blocks kept", blocks_o, 16);
    load(5'h02);
    burst(2, 1'b0, 1'b0);
    burst(2, 1'b1, 1'b0);
    $display("test bursts done");
  endtask
  initial begin
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    t_reset();
    t_cfg();
    t_bursts();
    give_verdict();
  end
endmodule
